/* rtl/hcef_pkg.sv */
// Purpose: Shared constants and types for the command/event packet framer
// Assumes: Byte-wide link, one clock domain
// Notes: Event opcodes and the data command boundary are local choices
package hcef_pkg;

  localparam int BYTE_W = 8;
  localparam int TX_IDX_W = 3;

  // Event opcodes (arbitrary values)
  localparam logic [7:0] OPC_REPLY = 8'h81;
  localparam logic [7:0] OPC_LINK_LOST = 8'h82;
  localparam logic [7:0] OPC_PEER_DATA = 8'h83;
  localparam logic [7:0] OPC_DATA_DONE = 8'h84;

  // Command opcodes at or above this value are data commands
  localparam logic [7:0] DATA_CMD_FIRST = 8'h40;

  // Reply status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_NOT_CONNECTED = 8'h01;

  // Payload byte counts of the event kinds
  localparam logic [1:0] PAY_NONE = 2'h0;
  localparam logic [1:0] PAY_PAIR = 2'h2;

  // Byte positions within an outgoing frame
  localparam logic [2:0] TX_IDX_LEN = 3'h0;
  localparam logic [2:0] TX_IDX_OP = 3'h1;
  localparam logic [2:0] TX_IDX_PAY = 3'h2;

  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_LAST = 8'h01;

  typedef struct packed {
    logic [7:0] opcode;
    logic is_data;
    logic [1:0] count;
    logic [23:0] pay;
  } hcef_event_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] len;
    logic is_data;
  } hcef_cmd_t;

  typedef enum {RX_LEN, RX_OP, RX_PAY} hcef_rx_state_t;

endpackage : hcef_pkg

/* rtl/hcef_framer.sv */
// Purpose: Parses command packets from the controller and frames events back
// Assumes: Byte stream inputs synchronous to clk_sys_i
// Notes: One reply pending at a time; receive stalls until it is loaded into the transmitter
//
// How it works
// R1: Each packet is a length byte and an opcode byte followed by a variable payload.
// R2: The length byte counts the opcode and payload bytes but not itself.
// R3: The opcode byte names the command or event and drives its decoding.
// R4: Multi-byte fields travel least significant byte first.
// R5: Strings travel leftmost character first, i.e. payload bytes in index order.
// R6: Controller packets are commands, either system or data commands.
// R7: Every event the device sends is marked as a system or a data event.
// R8: Every received command is answered with its own reply event.
// R9: Asynchronous events are sent whenever their condition occurs.
// R10: Data commands are acted on only while connected to a peer.
// R11: A successful data transfer is reported with a data event.
// R12: The receiver relies on the length byte since payload sizes vary.
// R13: Incoming bytes are framed in arrival order using the length byte first.
`timescale 1ns/10ps
module hcef_framer
  import hcef_pkg::*;
#(
  parameter int LEN_W = 8
)
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  input wire logic connected_i,
  output logic cmd_strobe_o,
  output hcef_cmd_t cmd_o,
  output logic payload_valid_o,
  output logic [7:0] payload_byte_o,
  input wire logic link_lost_i,
  input wire logic peer_data_i,
  input wire logic [15:0] peer_data_val_i,
  input wire logic data_done_i,
  input wire logic [15:0] data_done_val_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic tx_is_data_o
);

  if (LEN_W != BYTE_W)
  begin : g_len_check
    $error("Length field must be one byte wide");
  end

  hcef_rx_state_t rx_state;
  logic [7:0] rx_left;
  logic [7:0] rx_len;
  logic [7:0] rx_op;
  logic rx_ok;
  logic take;
  logic last_take;
  logic [7:0] cur_op;
  logic cur_data;
  logic cur_ok;

  logic reply_pend, lost_pend, done_pend, peer_pend;
  logic reply_clr, lost_clr, done_clr, peer_clr;
  hcef_event_t reply_ev;
  logic [15:0] done_val, peer_val;
  hcef_event_t next_ev;
  logic load;
  hcef_event_t cur_ev;
  logic [2:0] tx_idx;
  logic [2:0] tx_last;

  assign take = rx_valid_i && rx_ready_o;
  assign last_take = take && (rx_state != RX_LEN) && (rx_left == LEN_LAST); // see R12
  assign cur_op = (rx_state == RX_OP) ? rx_byte_i : rx_op; // see R3
  assign cur_data = (cur_op >= DATA_CMD_FIRST); // see R6
  assign cur_ok = (rx_state == RX_OP) ? (!cur_data || connected_i) : rx_ok; // see R10

  // Receive framing; zero-length packets carry no opcode and are skipped
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rx_state <= RX_LEN;
      rx_left <= LEN_ZERO;
      rx_len <= LEN_ZERO;
    end
    else if (take)
    begin
      case (rx_state)
        RX_LEN:
        begin
          rx_left <= rx_byte_i; // see R2, R13
          rx_len <= rx_byte_i;
          if (rx_byte_i != LEN_ZERO)
            rx_state <= RX_OP;
        end
        RX_OP:
        begin
          rx_left <= rx_left - LEN_LAST;
          rx_state <= (rx_left == LEN_LAST) ? RX_LEN : RX_PAY; // see R1
        end
        RX_PAY:
        begin
          rx_left <= rx_left - LEN_LAST;
          if (rx_left == LEN_LAST)
            rx_state <= RX_LEN;
        end
        default: rx_state <= RX_LEN;
      endcase
    end
  end

  // Opcode and admission latched at the opcode byte
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rx_op <= LEN_ZERO;
      rx_ok <= 1'b0;
    end
    else if (take && rx_state == RX_OP)
    begin
      rx_op <= rx_byte_i;
      rx_ok <= cur_ok;
    end
  end

  // Command and payload towards the core; refused data commands stay silent
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      cmd_strobe_o <= 1'b0;
      cmd_o <= '0;
      payload_valid_o <= 1'b0;
      payload_byte_o <= LEN_ZERO;
    end
    else
    begin
      cmd_strobe_o <= last_take && cur_ok; // see R10
      if (last_take)
        cmd_o <= '{opcode: cur_op, len: rx_len, is_data: cur_data};
      payload_valid_o <= take && (rx_state == RX_PAY) && rx_ok; // see R5
      payload_byte_o <= rx_byte_i;
    end
  end

  // Reply pending; receive stalls so a second reply can never be lost
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      reply_pend <= 1'b0;
      reply_ev <= '0;
      rx_ready_o <= 1'b0;
    end
    else
    begin
      reply_pend <= last_take || (reply_pend && !reply_clr); // see R8
      rx_ready_o <= !(last_take || (reply_pend && !reply_clr));
      if (last_take)
        reply_ev <= '{opcode: OPC_REPLY, is_data: cur_data, count: PAY_PAIR,
                      pay: {LEN_ZERO, (cur_ok ? ST_OK : ST_NOT_CONNECTED), cur_op}};
    end
  end

  // Asynchronous event flags; a new event in the clearing cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      lost_pend <= 1'b0;
      done_pend <= 1'b0;
      peer_pend <= 1'b0;
      done_val <= 16'h0000;
      peer_val <= 16'h0000;
    end
    else
    begin
      lost_pend <= link_lost_i || (lost_pend && !lost_clr); // see R9
      done_pend <= data_done_i || (done_pend && !done_clr); // see R11
      peer_pend <= peer_data_i || (peer_pend && !peer_clr); // see R9
      if (data_done_i)
        done_val <= data_done_val_i;
      if (peer_data_i)
        peer_val <= peer_data_val_i;
    end
  end

  // Replies first so the controller waits behind no pending event, only behind a frame already in flight
  always_comb
  begin
    reply_clr = 1'b0;
    lost_clr = 1'b0;
    done_clr = 1'b0;
    peer_clr = 1'b0;
    next_ev = reply_ev;
    if (reply_pend)
      reply_clr = load;
    else if (lost_pend)
    begin
      lost_clr = load;
      next_ev = '{opcode: OPC_LINK_LOST, is_data: 1'b0, count: PAY_NONE, pay: '0}; // see R7
    end
    else if (done_pend)
    begin
      done_clr = load;
      next_ev = '{opcode: OPC_DATA_DONE, is_data: 1'b1, count: PAY_PAIR,
                  pay: {LEN_ZERO, done_val}}; // see R7, R11
    end
    else
    begin
      peer_clr = load;
      next_ev = '{opcode: OPC_PEER_DATA, is_data: 1'b1, count: PAY_PAIR,
                  pay: {LEN_ZERO, peer_val}};
    end
  end

  assign load = !tx_valid_o && (reply_pend || lost_pend || done_pend || peer_pend);
  assign tx_last = TX_IDX_OP + {1'b0, cur_ev.count};

  function automatic logic [7:0] byte_at(input hcef_event_t ev, input logic [2:0] idx);
    logic [2:0] k;
    k = idx - TX_IDX_PAY;
    if (idx == TX_IDX_LEN)
      byte_at = {6'h00, ev.count} + LEN_LAST; // see R2
    else if (idx == TX_IDX_OP)
      byte_at = ev.opcode; // see R3
    else
      byte_at = ev.pay[8*k +: 8]; // see R4, R5
  endfunction : byte_at

  // Transmit framing; a byte is held until the controller takes it
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      tx_valid_o <= 1'b0;
      tx_byte_o <= LEN_ZERO;
      tx_is_data_o <= 1'b0;
      tx_idx <= TX_IDX_LEN;
      cur_ev <= '0;
    end
    else if (load)
    begin
      cur_ev <= next_ev;
      tx_valid_o <= 1'b1;
      tx_byte_o <= byte_at(next_ev, TX_IDX_LEN); // see R1
      tx_is_data_o <= next_ev.is_data;
      tx_idx <= TX_IDX_LEN;
    end
    else if (tx_valid_o && tx_ready_i)
    begin
      if (tx_idx == tx_last)
        tx_valid_o <= 1'b0;
      else
      begin
        tx_idx <= tx_idx + 3'h1;
        tx_byte_o <= byte_at(cur_ev, tx_idx + 3'h1);
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence tx_stall_s;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence tx_start_s;
    !tx_valid_o ##1 tx_valid_o;
  endsequence
  tx_hold_a: assert property (tx_stall_s |=> tx_valid_o && $stable(tx_byte_o)) // see R1
    else $error("Transmit byte changed while stalled");
  tx_len_byte_a: assert property (tx_start_s |-> tx_byte_o == {6'h00, cur_ev.count} + 8'h01) // see R2
    else $error("Frame length byte wrong");
  tx_opcode_a: assert property (tx_start_s ##0 tx_ready_i |=> tx_byte_o == cur_ev.opcode) // see R3
    else $error("Opcode byte does not follow length byte");
  tx_lsb_first_a: assert property (tx_valid_o && tx_idx == TX_IDX_PAY
                                   |-> tx_byte_o == cur_ev.pay[7:0]) // see R4
    else $error("Low payload byte not sent first");
  lost_class_a: assert property (tx_valid_o && cur_ev.opcode == OPC_LINK_LOST
                                 |-> !tx_is_data_o) // see R7
    else $error("Link lost event classed as data");
  reply_stall_a: assert property (last_take |=> !rx_ready_o && reply_pend) // see R8
    else $error("Reply not held pending after command");
  refuse_data_a: assert property (last_take |=> cmd_strobe_o == (reply_ev.pay[15:8] == ST_OK)) // see R10
    else $error("Command strobe disagrees with reply status");
  lost_catch_a: assert property (link_lost_i |=> lost_pend) // see R9
    else $error("Link lost event dropped");
  done_catch_a: assert property (data_done_i |=> done_pend && done_val == $past(data_done_val_i)) // see R11
    else $error("Data done event dropped");
  len_first_a: assert property (take && rx_state == RX_LEN && rx_byte_i != 8'h00
                                |=> rx_state == RX_OP && rx_left == $past(rx_byte_i)) // see R13
    else $error("Length byte not used to frame packet");

endmodule : hcef_framer

/* verification/hcef_ctrl_model.sv */
// Purpose: Controller model that sends command bytes and takes event bytes
// Assumes: Byte handshakes sampled on rising clk_sys_i
// Notes: Slow mode takes an event byte only every other cycle
`timescale 1ns/10ps
module hcef_ctrl_model
(
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_ready_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h5a;
    tx_ready_o = 1'b0;
  end
  // Stall pattern exercises held event bytes
  always @(posedge clk_sys_i)
  begin
    #1;
    tx_ready_o = slow_i ? ~tx_ready_o : 1'b1;
  end
  // Holds the byte until taken, giving up after 200 cycles
  task automatic send(input logic [7:0] b);
    int n;
    rx_valid_o = 1'b1;
    rx_byte_o = b;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (!rx_ready_i && n < 200);
    #1;
  endtask : send
  // Released line shows no stale byte
  task automatic idle();
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
  endtask : idle
endmodule : hcef_ctrl_model

/* verification/hcef_framer_tb.sv */
// Purpose: Self-checking bench for the command/event framer
// Assumes: One reply outstanding, inputs driven 1 ns after the edge
// Notes: Expected results queue up and a watcher pops them
`timescale 1ns/10ps
module hcef_framer_tb
  import hcef_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic rx_valid, rx_ready, connected = 1'b0, cmd_strobe, pay_v, slow = 1'b0;
  logic link_lost = 1'b0, peer_data = 1'b0, done = 1'b0;
  logic tx_ready, tx_valid, tx_is_data;
  logic [7:0] rx_byte, pay_b, tx_byte;
  logic [15:0] peer_val = 16'h0000, done_val = 16'h0000;
  hcef_cmd_t cmd;
  logic [8:0] evq[$];
  hcef_cmd_t cq[$];
  logic [7:0] pq[$];
  int n_fail = 0;
  int checks = 0;
  logic [31:0] seed = 32'h00000012;
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  hcef_framer hcef_framer_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready),
    .connected_i(connected), .cmd_strobe_o(cmd_strobe), .cmd_o(cmd),
    .payload_valid_o(pay_v), .payload_byte_o(pay_b), .link_lost_i(link_lost),
    .peer_data_i(peer_data), .peer_data_val_i(peer_val), .data_done_i(done),
    .data_done_val_i(done_val), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
    .tx_byte_o(tx_byte), .tx_is_data_o(tx_is_data));
  hcef_ctrl_model ctrl_inst (.clk_sys_i(clk_sys_i), .slow_i(slow), .rx_ready_i(rx_ready),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_ready_o(tx_ready));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic fail(input logic [16:0] g, input logic [16:0] e);
    n_fail++;
    $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask : fail
  task automatic chk_ev(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) fail(17'(g), 17'(e));
  endtask : chk_ev
  task automatic chk_cmd(input hcef_cmd_t g, input hcef_cmd_t e);
    checks++;
    if (g !== e) fail(g, e);
  endtask : chk_cmd
  task automatic chk_pay(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) fail(17'(g), 17'(e));
  endtask : chk_pay
  always @(posedge clk_sys_i)
  begin
    if (!reset_i && tx_valid === 1'b1 && tx_ready === 1'b1)
      if (evq.size() == 0) fail(17'(tx_byte), 17'h0);
      else chk_ev({tx_is_data, tx_byte}, evq.pop_front());
    if (!reset_i && cmd_strobe !== 1'b0)
      if (cq.size() == 0) fail(cmd, 17'h0);
      else chk_cmd(cmd, cq.pop_front());
    if (!reset_i && pay_v !== 1'b0)
      if (pq.size() == 0) fail(17'(pay_b), 17'h0);
      else chk_pay(pay_b, pq.pop_front());
  end
  task automatic ev(input logic d, input logic [7:0] op, input logic [15:0] p, input int n);
    evq.push_back({d, 8'(n + 1)});
    evq.push_back({d, op});
    if (n > 0) evq.push_back({d, p[7:0]});
    if (n > 0) evq.push_back({d, p[15:8]});
  endtask : ev
  task automatic settle();
    int n;
    n = 0;
    while (evq.size() + cq.size() + pq.size() != 0 && n < 300)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk_pay(8'(evq.size() + cq.size() + pq.size()), 8'h00);
  endtask : settle
  // Pending flags leave in order reply, link lost, data done, peer data
  task automatic fire(input logic [2:0] m, input logic [15:0] v);
    if (m[0]) ev(1'b0, OPC_LINK_LOST, v, 0);
    if (m[2]) ev(1'b1, OPC_DATA_DONE, v, 2);
    if (m[1]) ev(1'b1, OPC_PEER_DATA, v, 2);
    link_lost = m[0];
    peer_data = m[1];
    done = m[2];
    peer_val = v;
    done_val = v;
    @(posedge clk_sys_i);
    #1;
    {done, peer_data, link_lost} = 3'h0;
    settle();
  endtask : fire
  task automatic cmd_pkt(input logic [7:0] op, input int n);
    logic d;
    logic ok;
    logic [7:0] b;
    d = (op >= DATA_CMD_FIRST);
    ok = !d || connected;
    ctrl_inst.send(8'(n + 1));
    ctrl_inst.send(op);
    for (int i = 0; i < n; i++)
    begin
      b = rnd();
      if (ok) pq.push_back(b);
      ctrl_inst.send(b);
    end
    if (ok) cq.push_back('{op, 8'(n + 1), d});
    ev(d, OPC_REPLY, {ok ? ST_OK : ST_NOT_CONNECTED, op}, 2);
    ctrl_inst.idle();
    settle();
  endtask : cmd_pkt
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    #400000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      fire(3'b001, {rnd(), rnd()});
      cmd_pkt(8'h10, 1);
      cmd_pkt(8'h3f, 0);
      cmd_pkt(8'h41, 1);
      connected = 1'b1;
      cmd_pkt(8'h40, 2);
      ctrl_inst.send(8'h00);
      cmd_pkt(8'hff, 0);
      fire(3'b111, {rnd(), rnd()});
      fire(3'b100, {rnd(), rnd()});
      for (int i = 0; i < 6; i++)
      begin
        connected = rnd() > 8'h7f;
        cmd_pkt(rnd(), int'(rnd() % 8'h03));
      end
      connected = 1'b0;
      $display("test %0d done", s);
    end
    complete_run();
  end
endmodule : hcef_framer_tb
